/* hdl/dacp_defs.svh */
// address map, reset values and timing counts of the dac channel path
`ifndef DACP_DEFS_SVH
`define DACP_DEFS_SVH

`define DACP_KIND_IN     2'h0
`define DACP_KIND_GAIN   2'h1
`define DACP_KIND_OFS    2'h2
`define DACP_KIND_SPEC   2'h3
`define DACP_ADDR_CTRL   8'hC0
`define DACP_ADDR_SPAN0  8'hC1
`define DACP_ADDR_SPAN1  8'hC2
`define DACP_ADDR_SELALL 8'hC3
`define DACP_ADDR_SEL0   8'hC4
`define DACP_ADDR_SEL3   8'hC7
`define DACP_ADDR_STAT   8'hC8
`define DACP_BANK_BIT    2
`define DACP_X_RST16     16'h5554
`define DACP_X_RST14     16'h1555
`define DACP_M_RST16     16'hFFFF
`define DACP_M_RST14     16'h3FFF
`define DACP_C_RST16     16'h8000
`define DACP_C_RST14     16'h2000
`define DACP_SPAN_RST    14'h1555
`define DACP_CTRL_RST    3'h0
`define DACP_SEL_RST     8'h00
`define DACP_CLK_NS      20
`define DACP_SEL_BUSY_NS 500
`define DACP_SEL_BUSY_CYC ((`DACP_SEL_BUSY_NS + `DACP_CLK_NS - 1) / `DACP_CLK_NS)
`define DACP_INIT_CYC    16

`endif

/* hdl/dacp_pkg.sv */
// types shared by the dac channel path
`default_nettype none
package dacp_pkg;
    typedef enum logic [1:0] {
        DACP_IDLE,
        DACP_MUL,
        DACP_ADD
    } dacp_eng_t;
endpackage
`default_nettype wire

/* hdl/dacp_path.sv */
// per-channel input, trim, select and final dac registers of a 32-channel dac
//
// Behaviour
// - data writes go to input A when bank bit is 0, input B when 1
// - the bank bit is one global bit for all channels
// - each channel holds input A/B, gain, offset, calibrated A/B, final register
// - one shared multiplier and adder compute channels one after another
// - input or trim writes recompute calibrated A or B per bank bit
// - calibrated registers are not readable or writable by software
// - four 8-bit select registers, bit n picks calibrated A or B
// - a global command sets all select bits to 0 or to 1
// - load strobe low updates all final registers at once from selected source
// - final dac registers are not readable or writable by software
// - load strobe held low updates final registers whenever new data arrive
// - two 14-bit span offsets, group 0 and groups 1 to 3
// - clear low keeps outputs at group ground, registers still programmable
// - with clear high outputs stay disconnected until init sequence ends
// - 16-bit code = raw*(gain+1)/2^16 + offset - 2^15
// - 14-bit code = raw*(gain+1)/2^14 + offset - 2^13
// - span offset is scaled by 4 in the 16-bit variant only
// - both span offsets reset to 0x1555
// - busy is low while computing, no output update meanwhile
// - a load strobe seen during busy is kept and applied after busy ends
// - writing a select register drives busy low for about 500 ns
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`include "dacp_defs.svh"
`default_nettype none
module dacp_path #(
    parameter bit WIDE16 = 1'b1
) (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic [7:0]   addr_i,
    input  wire logic [15:0]  wdata_i,
    input  wire logic         we_i,
    input  wire logic         re_i,
    output logic      [15:0]  rdata_o,
    input  wire logic         load_strobe_n_i,
    input  wire logic         clear_n_i,
    output logic              busy_n_o,
    output logic              out_enable_o,
    output logic      [3:0]   group_signal_ground_o,
    output logic      [511:0] dac_code_o,
    output logic      [15:0]  span_sub_g0_o,
    output logic      [15:0]  span_sub_g1_o
);
    localparam logic [15:0] DMASK = WIDE16 ? 16'hFFFF : 16'h3FFF;
    localparam logic [15:0] DEF_X = WIDE16 ? `DACP_X_RST16 : `DACP_X_RST14;
    localparam logic [15:0] DEF_M = WIDE16 ? `DACP_M_RST16 : `DACP_M_RST14;
    localparam logic [15:0] DEF_C = WIDE16 ? `DACP_C_RST16 : `DACP_C_RST14;
    localparam logic [19:0] HALF  = WIDE16 ? 20'h08000 : 20'h02000;
    localparam logic [4:0]  SEL_BUSY = 5'(`DACP_SEL_BUSY_CYC);
    localparam logic [4:0]  INIT_CYC = 5'(`DACP_INIT_CYC);

    // lowest pending channel, used for both banks
    function automatic logic [4:0] first_set(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int k = 31; k >= 0; k--) begin
            if (v[k]) begin
                r = 5'(k);
            end
        end
        return r;
    endfunction

    // one-hot of a channel number
    function automatic logic [31:0] onehot(input logic [4:0] c);
        return 32'h0000_0001 << c;
    endfunction

    logic [15:0] in_a [32];
    logic [15:0] in_b [32];
    logic [15:0] gain [32];
    logic [15:0] ofs  [32];
    logic [15:0] cal_a [32];
    logic [15:0] cal_b [32];
    logic [2:0]  ctrl;
    logic [7:0]  sel [4];
    logic [13:0] span0;
    logic [13:0] span1;
    logic [31:0] pend_a;
    logic [31:0] pend_b;
    logic [31:0] clr_a;
    logic [31:0] clr_b;
    logic [31:0] set_a;
    logic [31:0] set_b;
    dacp_pkg::dacp_eng_t st;
    logic [4:0]  eng_ch;
    logic        eng_b;
    logic [32:0] prod;
    logic [15:0] next_cal;
    logic [4:0]  sel_cnt;
    logic [4:0]  init_cnt;
    logic        init_done;
    logic        ld_s1;
    logic        ld_s2;
    logic        ld_prev;
    logic        clr_s1;
    logic        clr_s2;
    logic        ld_pend;
    logic        busy;
    logic        do_load;
    logic        bank;
    logic [4:0]  ch;
    logic [1:0]  kind;
    logic        chan_ok;
    logic        wr_in;
    logic        wr_trim;
    logic        wr_sel;
    logic        wr_selall;

    // address decode: channel registers sit below 0xC0
    assign ch        = addr_i[4:0];
    assign kind      = addr_i[7:6];
    assign chan_ok   = (kind != `DACP_KIND_SPEC) && !addr_i[5];
    assign bank      = ctrl[`DACP_BANK_BIT];
    assign wr_in     = we_i && chan_ok && (kind == `DACP_KIND_IN);
    assign wr_trim   = we_i && chan_ok && (kind != `DACP_KIND_IN);
    assign wr_sel    = we_i && (addr_i >= `DACP_ADDR_SEL0) && (addr_i <= `DACP_ADDR_SEL3);
    assign wr_selall = we_i && (addr_i == `DACP_ADDR_SELALL);

    // input and trim registers of every channel
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 32; i++) begin
                in_a[i] <= DEF_X;
                in_b[i] <= DEF_X;
                gain[i] <= DEF_M;
                ofs[i]  <= DEF_C;
            end
        end else begin
            if (wr_in && !bank) begin
                in_a[ch] <= wdata_i & DMASK;
            end
            if (wr_in && bank) begin
                in_b[ch] <= wdata_i & DMASK;
            end
            if (wr_trim && (kind == `DACP_KIND_GAIN)) begin
                gain[ch] <= wdata_i & DMASK;
            end
            if (wr_trim && (kind == `DACP_KIND_OFS)) begin
                ofs[ch] <= wdata_i & DMASK;
            end
        end
    end

    // control, span offsets and source selects
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl  <= `DACP_CTRL_RST;
            span0 <= `DACP_SPAN_RST;
            span1 <= `DACP_SPAN_RST;
            for (int g = 0; g < 4; g++) begin
                sel[g] <= `DACP_SEL_RST;
            end
        end else if (we_i) begin
            if (addr_i == `DACP_ADDR_CTRL) begin
                ctrl <= wdata_i[2:0];
            end
            if (addr_i == `DACP_ADDR_SPAN0) begin
                span0 <= wdata_i[13:0];
            end
            if (addr_i == `DACP_ADDR_SPAN1) begin
                span1 <= wdata_i[13:0];
            end
            if (wr_sel) begin
                sel[addr_i[1:0]] <= wdata_i[7:0];
            end
            if (wr_selall) begin
                for (int g = 0; g < 4; g++) begin
                    sel[g] <= {8{wdata_i[0]}};
                end
            end
        end
    end

    // recompute requests: a write in the cycle the engine takes the flag wins
    always_comb begin
        set_a = 32'h0000_0000;
        set_b = 32'h0000_0000;
        if ((wr_in || wr_trim) && !bank) begin
            set_a = onehot(ch);
        end
        if ((wr_in || wr_trim) && bank) begin
            set_b = onehot(ch);
        end
    end

    // engine takes bank A requests before bank B
    always_comb begin
        clr_a = 32'h0000_0000;
        clr_b = 32'h0000_0000;
        if (st == dacp_pkg::DACP_IDLE) begin
            if (|pend_a) begin
                clr_a = onehot(first_set(pend_a));
            end else if (|pend_b) begin
                clr_b = onehot(first_set(pend_b));
            end
        end
    end

    // pending recompute flags
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pend_a <= 32'h0000_0000;
            pend_b <= 32'h0000_0000;
        end else begin
            pend_a <= (pend_a & ~clr_a) | set_a;
            pend_b <= (pend_b & ~clr_b) | set_b;
        end
    end

    // shared multiply-add engine, one channel at a time
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st     <= dacp_pkg::DACP_IDLE;
            eng_ch <= 5'h00;
            eng_b  <= 1'b0;
            prod   <= 33'h0_0000_0000;
        end else begin
            unique case (st)
                dacp_pkg::DACP_IDLE: begin
                    if (|pend_a) begin
                        eng_ch <= first_set(pend_a);
                        eng_b  <= 1'b0;
                        st     <= dacp_pkg::DACP_MUL;
                    end else if (|pend_b) begin
                        eng_ch <= first_set(pend_b);
                        eng_b  <= 1'b1;
                        st     <= dacp_pkg::DACP_MUL;
                    end
                end
                dacp_pkg::DACP_MUL: begin
                    // the single multiplier
                    prod <= (eng_b ? in_b[eng_ch] : in_a[eng_ch]) * ({1'b0, gain[eng_ch]} + 17'h0_0001);
                    st   <= dacp_pkg::DACP_ADD;
                end
                dacp_pkg::DACP_ADD: begin
                    st <= dacp_pkg::DACP_IDLE;
                end
            endcase
        end
    end

    // the single adder, with saturation instead of wrap
    always_comb begin
        logic [16:0] scaled;
        logic [19:0] sum;
        scaled = 17'h0_0000;
        sum    = 20'h0_0000;
        if (WIDE16) begin
            scaled = prod[32:16];
        end else begin
            scaled = prod[30:14];
        end
        sum = {3'b000, scaled} + {4'h0, ofs[eng_ch]} - HALF;
        if (sum[19]) begin
            next_cal = 16'h0000;
        end else if (sum > {4'h0, DMASK}) begin
            next_cal = DMASK;
        end else begin
            next_cal = sum[15:0];
        end
    end

    // calibrated registers: only the engine writes them
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < 32; i++) begin
                cal_a[i] <= DEF_X;
                cal_b[i] <= DEF_X;
            end
        end else if (st == dacp_pkg::DACP_ADD) begin
            if (eng_b) begin
                cal_b[eng_ch] <= next_cal;
            end else begin
                cal_a[eng_ch] <= next_cal;
            end
        end
    end

    // select writes hold busy for a fixed time
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            sel_cnt <= 5'h00;
        end else if (wr_sel || wr_selall) begin
            sel_cnt <= SEL_BUSY;
        end else if (sel_cnt != 5'h00) begin
            sel_cnt <= sel_cnt - 5'h01;
        end
    end

    // busy covers queued work too, so a burst of writes reads as one busy
    assign busy     = (|pend_a) || (|pend_b) || (st != dacp_pkg::DACP_IDLE) || (sel_cnt != 5'h00);
    assign busy_n_o = !busy;

    // pin synchronisers
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ld_s1   <= 1'b1;
            ld_s2   <= 1'b1;
            ld_prev <= 1'b1;
            clr_s1  <= 1'b0;
            clr_s2  <= 1'b0;
        end else begin
            ld_s1   <= load_strobe_n_i;
            ld_s2   <= ld_s1;
            ld_prev <= ld_s2;
            clr_s1  <= clear_n_i;
            clr_s2  <= clr_s1;
        end
    end

    // a held-low strobe loads as soon as busy ends; clear low ignores strobes
    assign do_load = !busy && clr_s2 && (!ld_s2 || ld_pend);

    // remembered strobe edge
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ld_pend <= 1'b0;
        end else begin
            ld_pend <= (ld_pend && !do_load) || (ld_prev && !ld_s2 && clr_s2);
        end
    end

    // final dac registers, all loaded in the same cycle
    for (genvar c = 0; c < 32; c++) begin : g_dac
        logic [15:0] dac;
        always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
                dac <= DEF_X;
            end else if (do_load) begin
                dac <= sel[c / 8][c % 8] ? cal_b[c] : cal_a[c];
            end
        end
        assign dac_code_o[c * 16 +: 16] = dac;
    end

    // init sequence keeps the outputs disconnected
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            init_cnt  <= 5'h00;
            init_done <= 1'b0;
        end else if (!init_done) begin
            init_cnt  <= init_cnt + 5'h01;
            init_done <= (init_cnt == INIT_CYC - 5'h01);
        end
    end

    // output switches and span subtraction terms
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            out_enable_o          <= 1'b0;
            group_signal_ground_o <= 4'hF;
            span_sub_g0_o         <= 16'h0000;
            span_sub_g1_o         <= 16'h0000;
        end else begin
            out_enable_o          <= init_done;
            group_signal_ground_o <= {4{!clr_s2}};
            span_sub_g0_o         <= WIDE16 ? {span0, 2'b00} : {2'b00, span0};
            span_sub_g1_o         <= WIDE16 ? {span1, 2'b00} : {2'b00, span1};
        end
    end

    // read data one cycle after the strobe; calibrated and final are unmapped
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            rdata_o <= 16'h0000;
        end else if (re_i) begin
            rdata_o <= 16'h0000;
            if (chan_ok) begin
                unique case (kind)
                    `DACP_KIND_IN:   rdata_o <= bank ? in_b[ch] : in_a[ch];
                    `DACP_KIND_GAIN: rdata_o <= gain[ch];
                    `DACP_KIND_OFS:  rdata_o <= ofs[ch];
                    default:         rdata_o <= 16'h0000;
                endcase
            end else if (addr_i == `DACP_ADDR_CTRL) begin
                rdata_o <= {13'h0000, ctrl};
            end else if (addr_i == `DACP_ADDR_SPAN0) begin
                rdata_o <= {2'b00, span0};
            end else if (addr_i == `DACP_ADDR_SPAN1) begin
                rdata_o <= {2'b00, span1};
            end else if (wr_sel || ((addr_i >= `DACP_ADDR_SEL0) && (addr_i <= `DACP_ADDR_SEL3))) begin
                rdata_o <= {8'h00, sel[addr_i[1:0]]};
            end else if (addr_i == `DACP_ADDR_STAT) begin
                rdata_o <= {12'h000, !clr_s2, ld_pend, init_done, busy};
            end
        end else begin
            rdata_o <= 16'h0000;
        end
    end
endmodule // dacp_path
`default_nettype wire

/* bench/dacp_path_asserts.sv */
// port-level checks of the dac channel path
`default_nettype none
module dacp_path_asserts #(
    parameter bit WIDE16 = 1'b1
) (
    input wire logic         clk_i,
    input wire logic         rstn_i,
    input wire logic [7:0]   addr_i,
    input wire logic         we_i,
    input wire logic         re_i,
    input wire logic [15:0]  rdata_o,
    input wire logic         clear_n_i,
    input wire logic         busy_n_o,
    input wire logic         out_enable_o,
    input wire logic [3:0]   group_signal_ground_o,
    input wire logic [511:0] dac_code_o,
    input wire logic [15:0]  span_sub_g0_o,
    input wire logic [15:0]  span_sub_g1_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] since_rst;

    // cycles since reset release, saturates so it never wraps back into the init window
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            since_rst <= 8'h00;
        end else if (since_rst != 8'hFF) begin
            since_rst <= since_rst + 8'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_init_hold: assert property (since_rst < 8'h10 |-> !out_enable_o)
        else $error("outputs connected before init ended");
    a_init_done: assert property (since_rst == 8'h14 |-> out_enable_o)
        else $error("outputs not connected after init");
    a_write_busy: assert property (we_i && addr_i < 8'hC0 && !addr_i[5] |=> !busy_n_o)
        else $error("data write did not raise busy");
    a_sel_busy: assert property (we_i && addr_i[7:2] == 6'h31 |=> !busy_n_o [*8])
        else $error("select write busy too short");
    a_no_busy_load: assert property ($changed(dac_code_o) |-> $past(busy_n_o))
        else $error("final codes changed while busy");
    a_clear_ground: assert property (!clear_n_i [*5] |-> group_signal_ground_o == 4'hF)
        else $error("clear low but outputs not grounded");
    a_clear_release: assert property (clear_n_i [*5] |-> group_signal_ground_o == 4'h0)
        else $error("clear high but outputs grounded");
    // ground lags the synced clear by one flop, so it trails the load gating by one cycle
    a_clear_holds: assert property (group_signal_ground_o[0] [*3] |-> $stable(dac_code_o))
        else $error("load taken while cleared");
    a_hidden_regs: assert property ($past(re_i) && $past(addr_i) < 8'hC0 && ($past(addr_i) & 8'h20) != 8'h00
        |-> rdata_o == 16'h0000)
        else $error("unmapped read returned data");
    a_span_scale: assert property (WIDE16 ? (span_sub_g0_o[1:0] == 2'h0 && span_sub_g1_o[1:0] == 2'h0)
        : (span_sub_g0_o[15:14] == 2'h0 && span_sub_g1_o[15:14] == 2'h0))
        else $error("span term not scaled for variant");
endmodule // dacp_path_asserts

bind dacp_path dacp_path_asserts #(.WIDE16(WIDE16)) u_asserts (
    .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .clear_n_i(clear_n_i), .busy_n_o(busy_n_o), .out_enable_o(out_enable_o),
    .group_signal_ground_o(group_signal_ground_o), .dac_code_o(dac_code_o),
    .span_sub_g0_o(span_sub_g0_o), .span_sub_g1_o(span_sub_g1_o)
);
`default_nettype wire

/* bench/dacp_host_pins.sv */
// host side pin model: load strobe and clear
`default_nettype none
module dacp_host_pins (
    input  wire logic clk_i,
    output logic      load_strobe_n_o,
    output logic      clear_n_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: no load pending, outputs released
    initial begin
        load_strobe_n_o = 1'b1;
        clear_n_o = 1'b1;
    end

    // three cycles low so the two-stage sync never misses it
    task automatic load_pulse;
        load_strobe_n_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        load_strobe_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask

    task automatic hold_load(input logic lvl);
        load_strobe_n_o <= lvl;
        @(posedge clk_i);
    endtask

    task automatic set_clear(input logic lvl);
        clear_n_o <= lvl;
        repeat (6) @(posedge clk_i);
    endtask
endmodule // dacp_host_pins
`default_nettype wire

/* bench/dac_channel_calibration_path_tb.sv */
// self-checking bench of the dac channel path
`include "dacp_defs.svh"
`default_nettype none
module dac_channel_calibration_path_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_i = 1'b0;
    logic         rstn_i = 1'b0;
    logic [7:0]   addr_i = 8'h00;
    logic [15:0]  wdata_i = 16'h0000;
    logic         we_i = 1'b0;
    logic         re_i = 1'b0;
    logic [15:0]  rdata_o;
    logic         load_n;
    logic         clr_n;
    logic         busy_n_o;
    logic         out_enable_o;
    logic [3:0]   ground;
    logic [511:0] codes;
    logic [15:0]  span0;
    logic [15:0]  span1;
    logic [511:0] codes14;
    logic [15:0]  span14;
    int           mismatches = 0;
    int           checked = 0;

    always #10 clk_i = ~clk_i;

    dacp_host_pins host (.clk_i(clk_i), .load_strobe_n_o(load_n), .clear_n_o(clr_n));

    dacp_path #(.WIDE16(1'b1)) dut (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
        .rdata_o(rdata_o), .load_strobe_n_i(load_n), .clear_n_i(clr_n), .busy_n_o(busy_n_o),
        .out_enable_o(out_enable_o), .group_signal_ground_o(ground), .dac_code_o(codes),
        .span_sub_g0_o(span0), .span_sub_g1_o(span1)
    );

    // 14-bit variant on the same stimulus; its engine timing matches the 16-bit one
    dacp_path #(.WIDE16(1'b0)) dut14 (
        .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
        .rdata_o(), .load_strobe_n_i(load_n), .clear_n_i(clr_n), .busy_n_o(),
        .out_enable_o(), .group_signal_ground_o(), .dac_code_o(codes14),
        .span_sub_g0_o(span14), .span_sub_g1_o()
    );

    task automatic end_of_test;
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one-cycle strobe, then a quiet cycle so strobes never reassign in one step
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 check(rdata_o, exp);
        @(posedge clk_i);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            #1 n++;
        end while (busy_n_o !== 1'b1 && n < 300);
        if (n >= 300) begin
            mismatches++;
            end_of_test();
        end
        @(posedge clk_i);
    endtask

    function automatic logic [15:0] code(input int ch);
        return codes[16*ch +: 16];
    endfunction

    function automatic logic [15:0] code14(input int ch);
        return codes14[16*ch +: 16];
    endfunction

    // trim result from the transfer function, clamped to the code range
    function automatic logic [15:0] calc(input int raw, input int m, input int c);
        longint v;
        v = ((longint'(raw) * (m + 1)) >>> 16) + c - 32'h8000;
        if (v < 0) v = 0;
        if (v > 32'hFFFF) v = 32'hFFFF;
        return v[15:0];
    endfunction

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        #1 check(16'(out_enable_o), 16'h0001);
        check(16'(ground), 16'h0000);
        check(code(0), `DACP_X_RST16);
        check(span0, 16'h5554);
        check(span14, 16'h1555);
        check(code14(0), `DACP_X_RST14);
        @(posedge clk_i);
        rd(`DACP_ADDR_SPAN1, 16'h1555);
        rd(`DACP_ADDR_SEL0, 16'h0000);
        rd(8'h23, 16'h0000);
        wr(`DACP_ADDR_CTRL, 16'h0000);
        wr(8'h03, 16'h1234);
        wr(`DACP_ADDR_CTRL, 16'h0004);
        wr(8'h03, 16'h2000);
        wr(8'h43, 16'h7FFF);
        wr(8'h83, 16'h0000);
        wait_idle();
        rd(8'h03, 16'h2000);
        host.load_pulse();
        #1 check(code(3), calc(32'h1234, 32'hFFFF, 32'h8000));
        check(code14(3), 16'h1234);
        @(posedge clk_i);
        wr(`DACP_ADDR_SEL0, 16'h0008);
        #1 check(16'(busy_n_o), 16'h0000);
        wait_idle();
        host.load_pulse();
        #1 check(code(3), calc(32'h2000, 32'h7FFF, 32'h0000));
        check(code14(3), 16'h0000);
        check(code(0), `DACP_X_RST16);
        @(posedge clk_i);
        wr(`DACP_ADDR_SELALL, 16'h0001);
        wait_idle();
        rd(`DACP_ADDR_SEL3, 16'h00FF);
        wr(`DACP_ADDR_SELALL, 16'h0000);
        wait_idle();
        rd(`DACP_ADDR_SEL0, 16'h0000);
        wr(`DACP_ADDR_SEL0, 16'h0008);
        wait_idle();
        host.set_clear(1'b0);
        #1 check(16'(ground), 16'h000F);
        @(posedge clk_i);
        wr(8'h83, 16'h8000);
        wait_idle();
        host.load_pulse();
        #1 check(code(3), 16'h0000);
        @(posedge clk_i);
        host.set_clear(1'b1);
        host.load_pulse();
        #1 check(code(3), calc(32'h2000, 32'h7FFF, 32'h8000));
        @(posedge clk_i);
        wr(8'h03, 16'h4000);
        wr(`DACP_ADDR_SEL0, 16'h0008);
        host.load_pulse();
        #1 check(code(3), calc(32'h2000, 32'h7FFF, 32'h8000));
        wait_idle();
        repeat (4) @(posedge clk_i);
        #1 check(code(3), calc(32'h4000, 32'h7FFF, 32'h8000));
        @(posedge clk_i);
        host.hold_load(1'b0);
        wr(8'h03, 16'h6000);
        wait_idle();
        repeat (4) @(posedge clk_i);
        #1 check(code(3), calc(32'h6000, 32'h7FFF, 32'h8000));
        @(posedge clk_i);
        host.hold_load(1'b1);
        wr(`DACP_ADDR_SPAN0, 16'h2000);
        wr(`DACP_ADDR_SPAN1, 16'h0100);
        repeat (2) @(posedge clk_i);
        #1 check(span0, 16'h8000);
        check(span1, 16'h0400);
        check(span14, 16'h2000);
        @(posedge clk_i);
        // full-scale trims on bank B push both variants past the top of the range
        wr(8'h83, 16'hFFFF);
        wr(8'h43, 16'hFFFF);
        wr(8'h03, 16'hFFFF);
        wait_idle();
        host.load_pulse();
        #1 check(code(3), calc(32'hFFFF, 32'hFFFF, 32'hFFFF));
        check(code14(3), 16'h3FFF);
        end_of_test();
    end
endmodule // dac_channel_calibration_path_tb
`default_nettype wire
